// >>> hw/mee_top.sv
/*
 * Orientation, wake-up and tap engines with their register file.
 * Assumes samples arrive from front-end logic on clk_sys with a one-cycle valid strobe.
 */
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "mee_map.svh"

module mee_top
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic smp_valid,
   input wire mee_pkg::mee_axes_t smp,
   input wire mee_pkg::mee_req_t req,
   output logic [7:0] rdata
);
   import mee_pkg::*;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Magnitude of a 17-bit difference
   function automatic logic [16:0] absv(input logic signed [16:0] v);
      absv = v[16] ? 17'(-v) : 17'(v);
   endfunction

   // Rate divider: an engine runs on one sample in 2**sel
   function automatic logic rate_hit(input logic [7:0] cnt, input logic [2:0] sel);
      rate_hit = (cnt & 8'((9'h001 << sel) - 9'h001)) == 8'h00;
   endfunction

   function automatic logic signed [16:0] dif(input logic signed [15:0] a,
                                              input logic signed [15:0] b);
      dif = 17'(a) - 17'(b);
   endfunction

   // ****************************************************************
   // Register port
   // ****************************************************************
   logic [7:0] ctrl3, hyst, tilt_lo, tilt_hi, tilt_tmr, activity_threshold, wqc;
   logic [7:0] tap_lo, tap_hi, tap_dur, tap_win;
   logic [3:0] evt;
   logic [2:0] tap_dir;
   mee_orient_t orient;
   wire wr_hit = req.wr;

   // Software settings; upper tilt limit starts at its preset
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         ctrl3 <= `MEE_RST_CTRL3;
         hyst <= `MEE_RST_HYST;
         tilt_lo <= `MEE_RST_TILT_LO;
         tilt_hi <= `MEE_RST_TILT_HI;
         tilt_tmr <= `MEE_RST_TILT_TMR;
         activity_threshold <= `MEE_RST_ATH;
         wqc <= `MEE_RST_WQC;
         tap_lo <= `MEE_RST_TAP_LO;
         tap_hi <= `MEE_RST_TAP_HI;
         tap_dur <= `MEE_RST_TAP_DUR;
         tap_win <= `MEE_RST_TAP_WIN;
      end
      else if (wr_hit)
      begin
         unique case (req.addr)
            `MEE_OFS_CTRL3: ctrl3 <= req.wdata;
            `MEE_OFS_HYST: hyst <= req.wdata;
            `MEE_OFS_TILT_LO: tilt_lo <= req.wdata;
            `MEE_OFS_TILT_HI: tilt_hi <= req.wdata;
            `MEE_OFS_TILT_TMR: tilt_tmr <= req.wdata;
            `MEE_OFS_ATH: activity_threshold <= req.wdata;
            `MEE_OFS_WQC: wqc <= req.wdata;
            `MEE_OFS_TAP_LO: tap_lo <= req.wdata;
            `MEE_OFS_TAP_HI: tap_hi <= req.wdata;
            `MEE_OFS_TAP_DUR: tap_dur <= req.wdata;
            `MEE_OFS_TAP_WIN: tap_win <= req.wdata;
            default: ;
         endcase
      end
   end

   // Read mux; unmapped offsets read zero
   logic [7:0] rd_mux;
   assign rd_mux = (req.addr == `MEE_OFS_CTRL3) ? ctrl3 :
                   (req.addr == `MEE_OFS_HYST) ? hyst :
                   (req.addr == `MEE_OFS_TILT_LO) ? tilt_lo :
                   (req.addr == `MEE_OFS_TILT_HI) ? tilt_hi :
                   (req.addr == `MEE_OFS_TILT_TMR) ? tilt_tmr :
                   (req.addr == `MEE_OFS_ATH) ? activity_threshold :
                   (req.addr == `MEE_OFS_WQC) ? wqc :
                   (req.addr == `MEE_OFS_TAP_LO) ? tap_lo :
                   (req.addr == `MEE_OFS_TAP_HI) ? tap_hi :
                   (req.addr == `MEE_OFS_TAP_DUR) ? tap_dur :
                   (req.addr == `MEE_OFS_TAP_WIN) ? tap_win :
                   (req.addr == `MEE_OFS_STATE) ? {5'h00, orient} :
                   (req.addr == `MEE_OFS_EVENT) ? {4'h0, evt} :
                   (req.addr == `MEE_OFS_TAP_DIR) ? {5'h00, tap_dir} : 8'h00;

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         rdata <= 8'h00;
      else
         rdata <= req.rd ? rd_mux : 8'h00;
   end

   // ****************************************************************
   // Engine rates
   // ****************************************************************
   logic [7:0] smp_cnt;
   wire tilt_tick = smp_valid && rate_hit(smp_cnt, {1'b0, ctrl3[`MEE_CTRL3_TILT_LSB +: 2]});
   wire tap_tick = smp_valid && rate_hit(smp_cnt, ctrl3[`MEE_CTRL3_TAP_LSB +: 3]);
   wire wake_tick = smp_valid && rate_hit(smp_cnt, ctrl3[`MEE_CTRL3_WAKE_LSB +: 3]);

   // One free-running counter divides the sample stream for all engines
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         smp_cnt <= 8'h00;
      else if (smp_valid)
         smp_cnt <= smp_cnt + 8'h01;
   end

   // ****************************************************************
   // Orientation engine
   // ****************************************************************
   wire [16:0] ax_full = absv(17'(smp.x));
   wire [16:0] ay_full = absv(17'(smp.y));
   wire [15:0] ax = ax_full[15:0];
   wire [15:0] ay = ay_full[15:0];
   wire [15:0] axy = (ax > ay) ? ax : ay;
   wire [8:0] tilt_g8 = 9'(axy >> `MEE_TILT_SHIFT);
   // Hysteresis widens with the setting; 15 gives the 0.5 g / 0.866 g pair
   wire [7:0] hyst_c = (hyst > 8'(`MEE_HYST_MAX)) ? 8'(`MEE_HYST_MAX) : hyst;
   wire [15:0] rot_lo = 16'(`MEE_ROT_LO_DEF + (`MEE_HYST_DEF - int'(hyst_c)) * `MEE_LO_SLOPE);
   wire [15:0] rot_hi = 16'(`MEE_ROT_HI_DEF - (`MEE_HYST_DEF - int'(hyst_c)) * `MEE_HI_SLOPE);
   // Flat at or below the lower limit; above the upper limit motion is treated as transient
   wire is_flat = tilt_g8 <= {1'b0, tilt_lo};
   wire is_jolt = tilt_g8 > {1'b0, tilt_hi};
   wire is_vert = ax < rot_lo && ay > rot_hi;
   wire is_horiz = ay < rot_lo && ax > rot_hi;

   // Candidate state; between the bands the current state stands
   mee_orient_t cand;
   assign cand = is_flat ? (smp.z[15] ? MEE_FACE_DOWN : MEE_FACE_UP) :
                 is_vert ? (smp.y[15] ? MEE_VERT_NEG : MEE_VERT_POS) :
                 is_horiz ? (smp.x[15] ? MEE_HORIZ_NEG : MEE_HORIZ_POS) : orient;

   mee_orient_t pend;
   logic [7:0] tilt_cnt;
   wire tilt_new = tilt_tick && !is_jolt && cand != orient;
   // A zero count means nothing is pending, so a stale candidate cannot shorten the wait
   wire tilt_same = pend == cand && tilt_cnt != 8'h00 && tilt_cnt != 8'hff;
   wire [7:0] tilt_next = tilt_same ? tilt_cnt + 8'h01 : 8'h01;
   // Commit once the candidate has held for the timer's count of sets
   wire tilt_commit = tilt_new && tilt_next >= tilt_tmr;

   // Debounce of a new orientation, one step per sample set taken at the tilt rate
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         orient <= MEE_FACE_UP;
         pend <= MEE_FACE_UP;
         tilt_cnt <= 8'h00;
      end
      else if (tilt_commit)
      begin
         orient <= cand;
         pend <= cand;
         tilt_cnt <= 8'h00;
      end
      else if (tilt_new)
      begin
         pend <= cand;
         tilt_cnt <= tilt_next;
      end
      else if (tilt_tick)
         tilt_cnt <= 8'h00;
   end
   wire orient_evt = tilt_commit;

   // ****************************************************************
   // Wake-up engine
   // ****************************************************************
   mee_wake_t wstate;
   mee_axes_t wprev, wref;
   logic [7:0] wcnt;
   // Difference against the previous sample when idle, the held reference when counting
   mee_axes_t wbase;
   assign wbase = (wstate == MEE_WAKE_COUNT) ? wref : wprev;
   // Threshold in steps of 256 raw counts, which is g/4 only at 1 g = 1024 counts
   wire [16:0] ath_c = {9'h000, activity_threshold};
   wire w_over = (absv(dif(smp.x, wbase.x)) >> `MEE_WAKE_SHIFT) > ath_c ||
                 (absv(dif(smp.y, wbase.y)) >> `MEE_WAKE_SHIFT) > ath_c ||
                 (absv(dif(smp.z, wbase.z)) >> `MEE_WAKE_SHIFT) > ath_c;
   wire w_start = wake_tick && wstate == MEE_WAKE_IDLE && w_over;
   wire w_done = wake_tick && wstate == MEE_WAKE_COUNT && w_over && wcnt + 8'h01 >= wqc;
   wire wake_evt = w_done || (w_start && wqc == 8'h00);

   // Qualification count in wake-rate periods
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         wstate <= MEE_WAKE_IDLE;
         wprev <= '0;
         wref <= '0;
         wcnt <= 8'h00;
      end
      else if (wake_tick)
      begin
         wprev <= smp;
         if (w_start && wqc != 8'h00)
         begin
            wstate <= MEE_WAKE_COUNT;
            wref <= smp;
            wcnt <= 8'h00;
         end
         else if (wstate == MEE_WAKE_COUNT && (!w_over || w_done))
            wstate <= MEE_WAKE_IDLE;
         else if (wstate == MEE_WAKE_COUNT)
            wcnt <= wcnt + 8'h01;
      end
   end

   // ****************************************************************
   // Tap engine
   // ****************************************************************
   mee_axes_t tprev;
   wire [16:0] jx = absv(dif(smp.x, tprev.x));
   wire [16:0] jy = absv(dif(smp.y, tprev.y));
   wire [16:0] jz = absv(dif(smp.z, tprev.z));
   wire [18:0] jerk = 19'(({2'b00, jx} + {2'b00, jy} + {2'b00, jz}) >> `MEE_TAP_SHIFT);
   wire t_high = jerk > {11'h000, tap_hi};
   wire t_low = jerk > {11'h000, tap_lo};
   // Axis of the strongest jerk component, with the sign of that axis's sample
   wire [2:0] t_dir = (jx >= jy && jx >= jz) ? {2'b00, smp.x[15]} :
                      (jy >= jz) ? {2'b01, smp.y[15]} : {2'b10, smp.z[15]};
   logic [7:0] trun, twin;
   logic [2:0] tdir_run;
   // Duration limits: the run must exceed the low nibble and stay below the high nibble
   wire t_end = tap_tick && !t_high && !t_low;
   wire t_hit = t_end && trun > {4'h0, tap_dur[3:0]} && trun < {4'h0, tap_dur[7:4]};
   wire t_double = t_hit && twin != 8'h00;
   wire t_single = tap_tick && twin == 8'h01 && !t_hit;

   // Run length above the low threshold; high-jerk samples are skipped
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         tprev <= '0;
         trun <= 8'h00;
         twin <= 8'h00;
         tdir_run <= 3'h0;
      end
      else if (tap_tick)
      begin
         tprev <= smp;
         if (t_low && !t_high && trun != 8'hff)
         begin
            trun <= trun + 8'h01;
            tdir_run <= t_dir;
         end
         else if (!t_high)
            trun <= 8'h00;
         // A second tap inside the window is a double; otherwise the window expiring is single
         if (t_hit && twin == 8'h00)
            twin <= (tap_win == 8'h00) ? 8'h01 : tap_win;
         else if (t_double)
            twin <= 8'h00;
         else if (twin != 8'h00)
            twin <= twin - 8'h01;
      end
   end

   // ****************************************************************
   // Event flags: write one to clear, a new event wins over the clear
   // ****************************************************************
   wire [3:0] evt_set = {t_double, t_single, wake_evt, orient_evt};
   wire [3:0] evt_clr = (req.wr && req.addr == `MEE_OFS_EVENT) ? req.wdata[3:0] : 4'h0;

   // Flags stand until acknowledged; engines never wait on them
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         evt <= 4'h0;
         tap_dir <= 3'h0;
      end
      else
      begin
         evt <= (evt & ~evt_clr) | evt_set;
         if (t_hit)
            tap_dir <= tdir_run;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   a_orient_change: assert property (orient != $past(orient) |-> $past(tilt_tick))
      else $error("Orientation changed without a tilt sample");
   a_flat_face: assert property (tilt_commit && is_flat |=> orient == MEE_FACE_UP
         || orient == MEE_FACE_DOWN)
      else $error("Flat device not classed face up or down");
   a_jolt_hold: assert property (tilt_tick && is_jolt |=> orient == $past(orient))
      else $error("Orientation moved during a transient");
   a_tilt_debounce: assert property (tilt_commit && tilt_tmr > 8'h01 |-> pend == cand)
      else $error("Orientation committed before debounce");
   a_wake_ref: assert property (wstate == MEE_WAKE_COUNT && !wake_tick |=> wref == $past(wref))
      else $error("Wake reference changed during count");
   a_wake_abandon: assert property (wake_tick && wstate == MEE_WAKE_COUNT && !w_over
         |=> wstate == MEE_WAKE_IDLE && !evt_set[1])
      else $error("Wake count not abandoned");
   a_wake_latch: assert property (wake_evt |=> evt[1] ##1 (evt[1] || $past(evt_clr[1])))
      else $error("Motion event not latched");
   a_tap_high: assert property (tap_tick && t_high |=> trun == $past(trun))
      else $error("High jerk sample changed tap run");
   a_flag_sticky: assert property (evt[0] && !evt_clr[0] |=> evt[0])
      else $error("Orientation flag dropped without acknowledge");
   a_read_late: assert property (!req.rd |=> rdata == 8'h00)
      else $error("Read data outside its cycle");
endmodule

// >>> hw/mee_map.svh
/*
 * Register offsets, reset values and scaling constants of the motion event engines.
 * Assumes it is included once by the package and by the top module.
 */
`ifndef MEE_MAP_SVH
`define MEE_MAP_SVH

// ****************************************************************
// Register offsets (6-bit word index on the register port)
// ****************************************************************
`define MEE_OFS_CTRL3 6'h00
`define MEE_OFS_HYST 6'h01
`define MEE_OFS_TILT_LO 6'h02
`define MEE_OFS_TILT_HI 6'h03
`define MEE_OFS_TILT_TMR 6'h04
`define MEE_OFS_ATH 6'h05
`define MEE_OFS_WQC 6'h06
`define MEE_OFS_TAP_LO 6'h07
`define MEE_OFS_TAP_HI 6'h08
`define MEE_OFS_TAP_DUR 6'h09
`define MEE_OFS_TAP_WIN 6'h0a
`define MEE_OFS_STATE 6'h0b
`define MEE_OFS_EVENT 6'h0c
`define MEE_OFS_TAP_DIR 6'h0d

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define MEE_CTRL3_TILT_LSB 6
`define MEE_CTRL3_TAP_LSB 3
`define MEE_CTRL3_WAKE_LSB 0
`define MEE_RST_CTRL3 8'h00
`define MEE_RST_HYST 8'h0f
`define MEE_RST_TILT_LO 8'h03
`define MEE_RST_TILT_HI 8'h0a
`define MEE_RST_TILT_TMR 8'h06
`define MEE_RST_ATH 8'h02
`define MEE_RST_WQC 8'h0a
`define MEE_RST_TAP_LO 8'h04
`define MEE_RST_TAP_HI 8'h30
`define MEE_RST_TAP_DUR 8'h41
`define MEE_RST_TAP_WIN 8'h10

// ****************************************************************
// Scaling: 1 g is 1024 counts on the sample input
// ****************************************************************
`define MEE_TILT_SHIFT 7
`define MEE_WAKE_SHIFT 8
`define MEE_TAP_SHIFT 6
`define MEE_ROT_LO_DEF 512
`define MEE_ROT_HI_DEF 887
`define MEE_HYST_DEF 15
`define MEE_HYST_MAX 45
`define MEE_LO_SLOPE 14
`define MEE_HI_SLOPE 10

`endif

// >>> hw/mee_pkg.sv
/*
 * Types shared by the motion event engines.
 * Assumes mee_map.svh is reachable on the include path.
 */
package mee_pkg;
`include "mee_map.svh"

   // One tri-axis sample, two's complement, 1 g = 1024 counts
   typedef struct packed {
      logic signed [15:0] x;
      logic signed [15:0] y;
      logic signed [15:0] z;
   } mee_axes_t;

   // One register port request
   typedef struct packed {
      logic [5:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } mee_req_t;

   typedef enum logic [2:0] {MEE_FACE_UP, MEE_FACE_DOWN, MEE_VERT_POS, MEE_VERT_NEG,
                             MEE_HORIZ_POS, MEE_HORIZ_NEG} mee_orient_t;

   typedef enum logic {MEE_WAKE_IDLE, MEE_WAKE_COUNT} mee_wake_t;
endpackage

// >>> tb/mee_host.sv
/*
 * Host processor model: issues register writes and reads on the register port.
 * Assumes the register port of mee_top, one clock, and a slave that never stalls.
 */
`timescale 1ns/10ps

module mee_host
(
   input wire logic clk_sys,
   output mee_pkg::mee_req_t req,
   input wire logic [7:0] rdata
);
   import mee_pkg::*;

   initial req = '0;

   // ****************************************************************
   // Bus cycles
   // ****************************************************************
   // One-cycle write strobe; released at the next edge
   task automatic wr(input logic [5:0] addr, input logic [7:0] data);
      @(posedge clk_sys);
      req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      req <= '0;
   endtask

   // Read data stands only in the cycle after the strobe, so take it at that edge
   task automatic rd(input logic [5:0] addr, output logic [7:0] data);
      @(posedge clk_sys);
      req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      req <= '0;
      @(posedge clk_sys);
      data = rdata;
   endtask
endmodule

// >>> tb/tb.sv
/*
 * Self-checking bench of the orientation and wake-up engines with an integer reference model.
 * Assumes mee_pkg, mee_map.svh, mee_top and the host model mee_host.
 */
`timescale 1ns/10ps
`include "mee_map.svh"

module tb;
   import mee_pkg::*;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic smp_valid = 1'b0;
   mee_axes_t smp = '0;
   mee_req_t req;
   logic [7:0] rdata;
   int failures = 0;
   int checks_done = 0;
   int cycles = 0;
   int nsmp = 0;
   int m_state = 0, m_pend = 0, m_tcnt = 0, m_flags = 0;
   int m_hyst = 15, m_lo = 3, m_hi = 10, m_tmr = 6, m_trate = 0;
   int w_ath = 2, w_wqc = 10, w_cnt = 0, w_busy = 0;
   int w_prev[3] = '{0, 0, 0};
   int w_ref[3] = '{0, 0, 0};
   logic [7:0] rst_val[13] = '{`MEE_RST_CTRL3, `MEE_RST_HYST, `MEE_RST_TILT_LO,
      `MEE_RST_TILT_HI, `MEE_RST_TILT_TMR, `MEE_RST_ATH, `MEE_RST_WQC, `MEE_RST_TAP_LO,
      `MEE_RST_TAP_HI, `MEE_RST_TAP_DUR, `MEE_RST_TAP_WIN, 8'h00, 8'h00};

   mee_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .smp_valid(smp_valid), .smp(smp),
                .req(req), .rdata(rdata));
   mee_host host (.clk_sys(clk_sys), .req(req), .rdata(rdata));

   // ****************************************************************
   // Clock, run limit and verdict
   // ****************************************************************
   always #4 clk_sys = ~clk_sys;

   // Roughly 110 samples and 250 reads fit well inside this ceiling
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         failures++;
         $display("Error at %0t: run limit reached", $time);
         finish_test();
      end
   end

   task automatic finish_test();
      $display("Counts: %0d checks, %0d mismatches", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ****************************************************************
   // Reference model
   // ****************************************************************
   function automatic int iabs(input int v);
      return (v < 0) ? -v : v;
   endfunction

   // Candidate must persist for the timer count of engine samples before it is taken
   task automatic orient_step(input int x, input int y, input int z);
      int mx, lo, hi, cand;
      mx = ((iabs(x) > iabs(y)) ? iabs(x) : iabs(y)) >> 7;
      lo = 512 + (15 - m_hyst) * 14;
      hi = 887 - (15 - m_hyst) * 10;
      cand = m_state;
      if (mx <= m_lo)
         cand = (z < 0) ? 1 : 0;
      else if (mx <= m_hi)
      begin
         if (iabs(x) < lo && y > hi) cand = 2;
         else if (iabs(x) < lo && y < -hi) cand = 3;
         else if (iabs(y) < lo && x > hi) cand = 4;
         else if (iabs(y) < lo && x < -hi) cand = 5;
      end
      if (cand == m_state)
         m_tcnt = 0;
      else
      begin
         m_tcnt = (cand == m_pend && m_tcnt > 0) ? m_tcnt + 1 : 1;
         m_pend = cand;
         if (m_tcnt >= m_tmr)
         begin
            m_state = cand;
            m_flags |= 1;
            m_tcnt = 0;
         end
      end
   endtask

   function automatic bit over(input int s[3], input int r[3]);
      return ((iabs(s[0] - r[0]) >> 8) > w_ath) || ((iabs(s[1] - r[1]) >> 8) > w_ath) ||
             ((iabs(s[2] - r[2]) >> 8) > w_ath);
   endfunction

   // Start on a jump against the previous sample, then hold the start sample as reference
   task automatic wake_step(input int s[3]);
      if (w_busy != 0)
      begin
         if (!over(s, w_ref)) w_busy = 0;
         else if (w_cnt + 1 >= w_wqc)
         begin
            m_flags |= 2;
            w_busy = 0;
         end
         else w_cnt++;
      end
      else if (over(s, w_prev))
      begin
         if (w_wqc == 0) m_flags |= 2;
         else
         begin
            w_busy = 1;
            w_cnt = 0;
            w_ref = s;
         end
      end
      w_prev = s;
   endtask

   // ****************************************************************
   // Stimulus and comparison
   // ****************************************************************
   // Small random noise on every axis keeps the values clear of the band edges
   task automatic send(input int bx, input int by, input int bz);
      int s[3];
      s[0] = bx + int'($urandom % 127) - 63;
      s[1] = by + int'($urandom % 127) - 63;
      s[2] = bz + int'($urandom % 127) - 63;
      @(posedge clk_sys);
      smp_valid <= 1'b1;
      smp <= {16'(s[0]), 16'(s[1]), 16'(s[2])};
      @(posedge clk_sys);
      smp_valid <= 1'b0;
      if (nsmp % (1 << m_trate) == 0) orient_step(s[0], s[1], s[2]);
      wake_step(s);
      nsmp++;
      repeat (2) @(posedge clk_sys);
   endtask

   task automatic check_reg(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m);
      logic [7:0] v;
      host.rd(a, v);
      checks_done++;
      if ((v & m) !== (e & m))
      begin
         failures++;
         $display("Error at %0t: reg %h read %h expected %h", $time, a, v, e);
      end
   endtask

   task automatic drive_orient(input int x, input int y, input int z, input int n);
      repeat (n)
      begin
         send(x, y, z);
         check_reg(`MEE_OFS_STATE, 8'(m_state), 8'hff);
         check_reg(`MEE_OFS_EVENT, 8'(m_flags), 8'h01);
      end
   endtask

   task automatic clear_flags(input int m);
      host.wr(`MEE_OFS_EVENT, 8'(m));
      m_flags &= ~m;
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      int tgt[6][3];
      logic [7:0] v;
      tgt = '{'{0, 1000, 0}, '{0, -1000, 0}, '{1000, 0, 0}, '{-1000, 0, 0},
              '{0, 0, -1024}, '{0, 0, 1024}};
      void'($urandom(9));
      repeat (3) @(posedge clk_sys);
      sys_rst <= 1'b0;
      for (int i = 0; i < 13; i++)
         check_reg(6'(i), rst_val[i], 8'hff);
      check_reg(6'h3f, 8'h00, 8'hff);
      $display("Test reset values done");
      for (int i = 0; i < 11; i++)
      begin
         if (i == 1) continue;
         v = 8'($urandom);
         host.wr(6'(i), v);
         check_reg(6'(i), v, 8'hff);
         host.wr(6'(i), rst_val[i]);
      end
      host.wr(`MEE_OFS_STATE, 8'h55);
      check_reg(`MEE_OFS_STATE, 8'h00, 8'hff);
      $display("Test register access done");
      host.wr(`MEE_OFS_ATH, 8'hff);
      w_ath = 255;
      drive_orient(0, 1000, 0, 3);
      drive_orient(0, 0, 1024, 1);
      for (int i = 0; i < 6; i++)
      begin
         drive_orient(tgt[i][0], tgt[i][1], tgt[i][2], 6);
         check_reg(`MEE_OFS_EVENT, 8'(m_flags), 8'h01);
         clear_flags(1);
         check_reg(`MEE_OFS_EVENT, 8'(m_flags), 8'h01);
      end
      $display("Test orientation walk done");
      drive_orient(0, 1500, 0, 8);
      host.wr(`MEE_OFS_TILT_HI, 8'h0f);
      m_hi = 15;
      drive_orient(0, 1500, 0, 6);
      host.wr(`MEE_OFS_TILT_HI, `MEE_RST_TILT_HI);
      m_hi = 10;
      drive_orient(0, 0, 1024, 6);
      host.wr(`MEE_OFS_TILT_LO, 8'h08);
      m_lo = 8;
      drive_orient(0, 1000, 1024, 8);
      host.wr(`MEE_OFS_TILT_LO, `MEE_RST_TILT_LO);
      m_lo = 3;
      $display("Test tilt limits done");
      drive_orient(820, 0, 0, 8);
      host.wr(`MEE_OFS_HYST, 8'h00);
      m_hyst = 0;
      drive_orient(820, 0, 0, 6);
      host.wr(`MEE_OFS_HYST, `MEE_RST_HYST);
      m_hyst = 15;
      host.wr(`MEE_OFS_CTRL3, 8'h40);
      m_trate = 1;
      drive_orient(0, 1000, 0, 13);
      host.wr(`MEE_OFS_CTRL3, 8'h00);
      m_trate = 0;
      drive_orient(0, 0, 1024, 6);
      clear_flags(1);
      $display("Test hysteresis and tilt rate done");
      host.wr(`MEE_OFS_ATH, `MEE_RST_ATH);
      w_ath = 2;
      host.wr(`MEE_OFS_WQC, 8'h03);
      w_wqc = 3;
      foreach (tgt[i])
         tgt[i] = '{0, 0, 1024};
      tgt[1][0] = 1000;
      tgt[2][0] = 1100;
      tgt[3][0] = 2100;
      for (int i = 0; i < 9; i++)
      begin
         send((i < 4) ? tgt[i][0] : 3100, 0, 1024);
         check_reg(`MEE_OFS_EVENT, 8'(m_flags), 8'h02);
      end
      check_reg(`MEE_OFS_EVENT, 8'h02, 8'h02);
      clear_flags(2);
      check_reg(`MEE_OFS_EVENT, 8'(m_flags), 8'h02);
      $display("Test wake-up done");
      finish_test();
   end
endmodule
